/* File: rtl/ocd_pkg.sv */
// Constants and types shared by the oscillator source and divider block
package ocd_pkg;

    // Register indexes on the plain register port
    localparam logic [3:0] OCD_ADDR_CLOCK_DIVISOR_REG = 4'h0;
    localparam logic [3:0] OCD_ADDR_FBDIV = 4'h1;
    localparam logic [3:0] OCD_ADDR_TUNE = 4'h2;
    localparam logic [3:0] OCD_ADDR_CTRL = 4'h3;

    // Field positions of clock_divisor_reg
    localparam int OCD_RCDIV_LSB = 8;
    localparam int OCD_POST_LSB = 6;
    localparam int OCD_PRE_LSB = 0;
    // Field positions of the control register
    localparam int OCD_CUR_LSB = 12;
    localparam int OCD_NEXT_LSB = 8;
    localparam int OCD_SWITCH_BIT = 0;

    // Values after reset
    localparam logic [2:0] OCD_RCDIV_RST = 3'h0;
    localparam logic [1:0] OCD_POST_RST = 2'h1;
    localparam logic [4:0] OCD_PRE_RST = 5'h00;
    localparam logic [8:0] OCD_FBDIV_RST = 9'h030;
    localparam logic [5:0] OCD_TUNE_RST = 6'h00;

    // Multiplier and prescaler offsets, fixed post-RC divide, RC postscale divide by 256
    localparam logic [9:0] OCD_FB_OFFSET = 10'h002;
    localparam logic [5:0] OCD_PRE_OFFSET = 6'h02;
    localparam logic [8:0] OCD_DIV16 = 9'h010;
    localparam logic [8:0] OCD_DIV256 = 9'h100;

    // Postscaler codes of the PLL
    localparam logic [1:0] OCD_POST_DIV2 = 2'h0;
    localparam logic [1:0] OCD_POST_DIV4 = 2'h1;
    localparam logic [1:0] OCD_POST_RSVD = 2'h2;
    localparam logic [1:0] OCD_POST_DIV8 = 2'h3;

    // Primary oscillator types
    localparam logic [1:0] OCD_PRI_EXT = 2'h0;
    localparam logic [1:0] OCD_PRI_STD = 2'h1;
    localparam logic [1:0] OCD_PRI_FAST = 2'h2;

    // Number of oscillator inputs and their index positions
    localparam int OCD_NUM_OSC = 4;
    localparam int OCD_OSC_FAST_RC = 0;
    localparam int OCD_OSC_PRIMARY = 1;
    localparam int OCD_OSC_SECONDARY = 2;
    localparam int OCD_OSC_SLOW_RC = 3;
    // Cycles after reset release before oscillator edges are believed
    localparam logic [1:0] OCD_ARM_LAST = 2'h3;

    typedef enum logic [2:0] {
        OCD_SRC_RC = 3'h0,
        OCD_SRC_RC_PLL = 3'h1,
        OCD_SRC_PRI = 3'h2,
        OCD_SRC_PRI_PLL = 3'h3,
        OCD_SRC_SEC = 3'h4,
        OCD_SRC_SLOW_RC = 3'h5,
        OCD_SRC_RC_DIV16 = 3'h6,
        OCD_SRC_RC_POST = 3'h7
    } ocd_source_t;

endpackage

/* File: rtl/ocd_osc_divider.sv */
// Oscillator source selection, fast RC postscaler, PLL rate model and halving
//
// Function
// - Fast RC clock divided by software three-bit postscale factor.
// - Software writes a tuning value that trims the fast RC frequency.
// - Power-on source chosen from initial source and primary mode fields.
// - Unprogrammed configuration starts from the fast RC oscillator.
// - Eight system clock options selectable.
// - Primary accepts standard crystal, high-speed crystal or external clock.
// - Slow RC clock is reference for watchdog and clock fail monitor.
// - Only fast RC and primary can pass through the PLL.
// - System clock divided by two gives instruction and peripheral clocks.
// - PLL input prescaled by 2 to 33 from five-bit field.
// - VCO input multiplied by nine-bit feedback field factor.
// - Feedback multiplier is field value plus two.
// - VCO output divided by 2, 4 or 8 from two-bit field.
// - PLL output equals input times multiplier over prescale times postscale.
// - Postscale codes: 00 div2, 01 div4 reset, 10 reserved, 11 div8.
// - Prescale code 0 to 31 divides by 2 to 33, reset 0.
// - RC postscale codes 0..6 divide by 1..64, 7 by 256.
// - Source codes 0..7: RC, RC PLL, primary, primary PLL, secondary, slow, div16, postscaled.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/100ps
module ocd_osc_divider
    import ocd_pkg::*;
#(
    parameter logic [8:0] FBDIV_RESET = OCD_FBDIV_RST
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic fast_internal_rc_i,
    input wire logic osc_in_pin_i,
    input wire logic secondary_osc_in_pin_i,
    input wire logic slow_internal_rc_i,
    input wire logic [2:0] initial_source_sel_i,
    input wire logic [1:0] primary_mode_sel_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic sys_tick_o,
    output logic instr_tick_o,
    output logic peripheral_time_base_o,
    output logic instr_clk_o,
    output logic watchdog_timer_tick_o,
    output logic clock_fail_monitor_tick_o,
    output logic [5:0] rc_tune_o,
    output logic primary_amp_en_o,
    output logic secondary_amp_en_o,
    output logic [2:0] current_source_code_o
);

    // Oscillator inputs: two-flop synchroniser then edge detect
    logic [OCD_NUM_OSC-1:0] osc_raw;
    logic [OCD_NUM_OSC-1:0] osc_tick;
    assign osc_raw = {slow_internal_rc_i, secondary_osc_in_pin_i,
                      osc_in_pin_i, fast_internal_rc_i};

    // Ticks masked until the edge detector holds samples taken after reset
    logic [1:0] osc_arm_q;
    logic osc_armed;
    assign osc_armed = (osc_arm_q == OCD_ARM_LAST);
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            osc_arm_q <= 2'h0;
        end else if (!osc_armed) begin
            osc_arm_q <= osc_arm_q + 2'h1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < OCD_NUM_OSC; gi++) begin : g_osc
            logic s1_q;
            logic s2_q;
            logic s3_q;
            always_ff @(posedge clock_i or posedge reset_i) begin
                if (reset_i) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                end else begin
                    s1_q <= osc_raw[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end
            assign osc_tick[gi] = s2_q & ~s3_q & osc_armed;
        end
    endgenerate

    // Strap synchroniser has no reset, so it fills while reset is held
    logic [4:0] cfg_s1_q;
    logic [4:0] cfg_s2_q;
    logic cfg_taken_q;
    logic [2:0] strap_src;
    logic [1:0] strap_mode;
    always_ff @(posedge clock_i) begin
        cfg_s1_q <= {primary_mode_sel_i, initial_source_sel_i};
        cfg_s2_q <= cfg_s1_q;
    end
    assign strap_src = cfg_s2_q[2:0];
    assign strap_mode = cfg_s2_q[4:3];

    // Software registers
    logic [2:0] rc_postscale_sel_q;
    logic [1:0] pll_postscale_sel_q;
    logic [4:0] pll_prescale_sel_q;
    logic [8:0] pll_feedback_sel_q;
    logic [5:0] tune_q;
    logic [2:0] next_source_code_q;
    logic [2:0] cur_q;
    logic [1:0] pri_mode_q;

    logic wr_div;
    logic wr_fb;
    logic wr_tune;
    logic wr_ctrl;
    logic switch_req;
    logic [2:0] next_sel;
    assign wr_div = wr_i && (addr_i == OCD_ADDR_CLOCK_DIVISOR_REG);
    assign wr_fb = wr_i && (addr_i == OCD_ADDR_FBDIV);
    assign wr_tune = wr_i && (addr_i == OCD_ADDR_TUNE);
    assign wr_ctrl = wr_i && (addr_i == OCD_ADDR_CTRL);
    assign switch_req = wr_ctrl && wdata_i[OCD_SWITCH_BIT];
    assign next_sel = wdata_i[OCD_NEXT_LSB +: 3];

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rc_postscale_sel_q <= OCD_RCDIV_RST;
            pll_postscale_sel_q <= OCD_POST_RST;
            pll_prescale_sel_q <= OCD_PRE_RST;
        end else if (wr_div) begin
            rc_postscale_sel_q <= wdata_i[OCD_RCDIV_LSB +: 3];
            pll_postscale_sel_q <= wdata_i[OCD_POST_LSB +: 2];
            pll_prescale_sel_q <= wdata_i[OCD_PRE_LSB +: 5];
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            pll_feedback_sel_q <= FBDIV_RESET;
            tune_q <= OCD_TUNE_RST;
        end else begin
            if (wr_fb) begin
                pll_feedback_sel_q <= wdata_i[8:0];
            end
            if (wr_tune) begin
                tune_q <= wdata_i[5:0];
            end
        end
    end

    // Source: strap at power-on, replaced only by a switch request
    // A control write in the strap load cycle is dropped
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_taken_q <= 1'b0;
            cur_q <= OCD_SRC_RC_POST;
            pri_mode_q <= OCD_PRI_EXT;
            next_source_code_q <= OCD_SRC_RC_POST;
        end else if (!cfg_taken_q) begin
            cfg_taken_q <= 1'b1;
            cur_q <= strap_src;
            pri_mode_q <= strap_mode;
            next_source_code_q <= strap_src;
        end else if (wr_ctrl) begin
            next_source_code_q <= next_sel;
            if (switch_req) begin
                cur_q <= next_sel;
            end
        end
    end

    // Fast RC postscaler divide value
    logic [8:0] rc_div;
    assign rc_div = (rc_postscale_sel_q == 3'h7) ? OCD_DIV256
                  : 9'(9'h001 << rc_postscale_sel_q);

    // Post divider for the fast RC: postscaled or fixed divide by sixteen
    logic [8:0] rc_cnt_q;
    logic [8:0] rc_div_sel;
    logic rc_div_tick;
    assign rc_div_sel = (cur_q == OCD_SRC_RC_DIV16) ? OCD_DIV16 : rc_div;
    assign rc_div_tick = osc_tick[OCD_OSC_FAST_RC] && (rc_cnt_q >= rc_div_sel - 9'h001);
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rc_cnt_q <= 9'h000;
        end else if (osc_tick[OCD_OSC_FAST_RC]) begin
            rc_cnt_q <= rc_div_tick ? 9'h000 : rc_cnt_q + 9'h001;
        end
    end

    // PLL rate model: accumulate M per input edge, emit per N1*N2
    logic [9:0] fb_mult;
    logic [5:0] pre_factor;
    logic [3:0] post_factor;
    logic [9:0] pll_den;
    logic pll_in_tick;
    logic [16:0] acc_sum;
    logic [15:0] acc_q;
    logic pll_tick;
    assign fb_mult = {1'b0, pll_feedback_sel_q} + OCD_FB_OFFSET;
    assign pre_factor = {1'b0, pll_prescale_sel_q} + OCD_PRE_OFFSET;
    // Reserved code behaves as divide by four
    assign post_factor = (pll_postscale_sel_q == OCD_POST_DIV2) ? 4'h2
                       : (pll_postscale_sel_q == OCD_POST_DIV8) ? 4'h8 : 4'h4;
    assign pll_den = 10'(pre_factor * post_factor);
    // Only fast RC or primary feed the PLL
    assign pll_in_tick = (cur_q == OCD_SRC_RC_PLL) ? osc_tick[OCD_OSC_FAST_RC]
                       : osc_tick[OCD_OSC_PRIMARY];
    assign acc_sum = {1'b0, acc_q} + (pll_in_tick ? {7'h00, fb_mult} : 17'h00000);
    assign pll_tick = acc_sum >= {7'h00, pll_den};
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            acc_q <= 16'h0000;
        end else if (pll_tick) begin
            acc_q <= (acc_sum[16]) ? 16'hFFFF : 16'(acc_sum - {7'h00, pll_den});
        end else begin
            acc_q <= acc_sum[15:0];
        end
    end

    // System oscillator selection
    logic sys_tick;
    always_comb begin
        unique case (cur_q)
            OCD_SRC_RC: sys_tick = osc_tick[OCD_OSC_FAST_RC];
            OCD_SRC_RC_PLL: sys_tick = pll_tick;
            OCD_SRC_PRI: sys_tick = osc_tick[OCD_OSC_PRIMARY];
            OCD_SRC_PRI_PLL: sys_tick = pll_tick;
            OCD_SRC_SEC: sys_tick = osc_tick[OCD_OSC_SECONDARY];
            OCD_SRC_SLOW_RC: sys_tick = osc_tick[OCD_OSC_SLOW_RC];
            OCD_SRC_RC_DIV16: sys_tick = rc_div_tick;
            OCD_SRC_RC_POST: sys_tick = rc_div_tick;
        endcase
    end

    // Halving and outputs
    logic instr_clk_d;
    assign instr_clk_d = sys_tick ? ~instr_clk_o : instr_clk_o;
    logic instr_fall;
    assign instr_fall = sys_tick && instr_clk_o;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            sys_tick_o <= 1'b0;
            instr_clk_o <= 1'b0;
            instr_tick_o <= 1'b0;
            peripheral_time_base_o <= 1'b0;
        end else begin
            sys_tick_o <= sys_tick;
            instr_clk_o <= instr_clk_d;
            instr_tick_o <= instr_fall;
            peripheral_time_base_o <= instr_fall;
        end
    end

    logic pri_selected;
    logic pri_crystal;
    assign pri_selected = (cur_q == OCD_SRC_PRI) || (cur_q == OCD_SRC_PRI_PLL);
    assign pri_crystal = (pri_mode_q == OCD_PRI_STD) || (pri_mode_q == OCD_PRI_FAST);
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            watchdog_timer_tick_o <= 1'b0;
            clock_fail_monitor_tick_o <= 1'b0;
            rc_tune_o <= OCD_TUNE_RST;
            primary_amp_en_o <= 1'b0;
            secondary_amp_en_o <= 1'b0;
            current_source_code_o <= OCD_SRC_RC_POST;
        end else begin
            watchdog_timer_tick_o <= osc_tick[OCD_OSC_SLOW_RC];
            clock_fail_monitor_tick_o <= osc_tick[OCD_OSC_SLOW_RC];
            rc_tune_o <= tune_q;
            primary_amp_en_o <= pri_selected && pri_crystal;
            secondary_amp_en_o <= (cur_q == OCD_SRC_SEC);
            current_source_code_o <= cur_q;
        end
    end

    // Read data, one cycle after the strobe
    // Reserved and unmapped bits read as zero
    logic [15:0] rd_mux;
    assign rd_mux = (addr_i == OCD_ADDR_CLOCK_DIVISOR_REG) ? {5'h00, rc_postscale_sel_q,
                        pll_postscale_sel_q, 1'b0, pll_prescale_sel_q}
                  : (addr_i == OCD_ADDR_FBDIV) ? {7'h00, pll_feedback_sel_q}
                  : (addr_i == OCD_ADDR_TUNE) ? {10'h000, tune_q}
                  : (addr_i == OCD_ADDR_CTRL) ? {1'b0, cur_q, 1'b0, next_source_code_q, 8'h00}
                  : 16'h0000;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= rd_i ? rd_mux : 16'h0000;
        end
    end

endmodule

/* File: dv/ocd_osc_model.sv */
// Free-running oscillator sources facing the block's clock inputs
`timescale 1ns/100ps
module ocd_osc_model #(
    parameter real RC_HALF = 40.0,
    parameter real PRI_HALF = 50.0,
    parameter real SEC_HALF = 80.0,
    parameter real SLOW_HALF = 100.0
) (
    output logic fast_rc_o,
    output logic primary_o,
    output logic secondary_o,
    output logic slow_rc_o
);
    // Odd start offsets keep the sources unrelated to the system clock
    initial begin
        fast_rc_o = 1'b0;
        #3.3;
        forever #(RC_HALF) fast_rc_o = ~fast_rc_o;
    end
    // External clock driven straight onto the oscillator input pin
    initial begin
        primary_o = 1'b0;
        #1.7;
        forever #(PRI_HALF) primary_o = ~primary_o;
    end
    initial begin
        secondary_o = 1'b0;
        #6.1;
        forever #(SEC_HALF) secondary_o = ~secondary_o;
    end
    // Slow RC scaled down in period to keep the run short
    initial begin
        slow_rc_o = 1'b0;
        #2.9;
        forever #(SLOW_HALF) slow_rc_o = ~slow_rc_o;
    end
endmodule

/* File: dv/ocd_osc_divider_monitor.sv */
// Concurrent checks on the ports of the oscillator divider block
`timescale 1ns/100ps
module ocd_osc_divider_monitor
    import ocd_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire logic instr_tick_o,
    input wire logic peripheral_time_base_o,
    input wire logic instr_clk_o,
    input wire logic watchdog_timer_tick_o,
    input wire logic clock_fail_monitor_tick_o,
    input wire logic [5:0] rc_tune_o,
    input wire logic [2:0] current_source_code_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    logic [1:0] age_q;
    wire sw_w = wr_i && addr_i == OCD_ADDR_CTRL && wdata_i[OCD_SWITCH_BIT];
    // Masks the strap load that follows each reset release
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    sequence s_req;
        sw_w;
    endsequence
    sequence s_rd(logic [3:0] a);
        rd_i && addr_i == a;
    endsequence
    a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data not zero outside read cycle");
    a_periph_equal: assert property (peripheral_time_base_o == instr_tick_o)
        else $error("peripheral tick differs from instruction tick");
    a_instr_fall: assert property (instr_tick_o |-> $fell(instr_clk_o))
        else $error("instruction tick without falling instruction clock");
    a_wdt_ref: assert property (watchdog_timer_tick_o == clock_fail_monitor_tick_o)
        else $error("watchdog and monitor references differ");
    a_switch_src: assert property (s_req |-> ##2
        current_source_code_o == $past(wdata_i[OCD_NEXT_LSB+:3], 2))
        else $error("source switch not applied");
    a_source_held: assert property ($changed(current_source_code_o) && age_q == 2'h3
        |-> $past(sw_w, 2))
        else $error("source changed without request");
    a_tune_read: assert property (s_rd(OCD_ADDR_TUNE) |=>
        rdata_o == {10'h000, rc_tune_o})
        else $error("tune read mismatch");
    a_unmapped_zero: assert property (rd_i && addr_i > OCD_ADDR_CTRL |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_cur_read: assert property (s_rd(OCD_ADDR_CTRL) |=>
        rdata_o[14:12] == current_source_code_o && !rdata_o[0])
        else $error("current source read mismatch");
endmodule
bind ocd_osc_divider ocd_osc_divider_monitor u_monitor (.clock_i(clock_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .instr_tick_o(instr_tick_o), .peripheral_time_base_o(peripheral_time_base_o),
    .instr_clk_o(instr_clk_o), .watchdog_timer_tick_o(watchdog_timer_tick_o),
    .clock_fail_monitor_tick_o(clock_fail_monitor_tick_o), .rc_tune_o(rc_tune_o),
    .current_source_code_o(current_source_code_o));

/* File: dv/testbench.sv */
// Self-checking bench for the oscillator source and divider block
`timescale 1ns/100ps
module testbench import ocd_pkg::*;;
    logic clock_i, reset_i, wr_i, rd_i;
    logic [2:0] strap;
    logic [1:0] mode;
    logic [3:0] addr_i;
    logic [15:0] wdata_i;
    wire rc, pri, sec, slow, sys_t, ins_t, ptb, ins_c, wdt, cfm, pamp, samp;
    wire [15:0] rdata;
    wire [5:0] tune;
    wire [2:0] cur;
    int failures, compares, n_sys, n_ins, n_wdt;
    ocd_osc_model u_ocd_osc_model (.fast_rc_o(rc), .primary_o(pri), .secondary_o(sec),
        .slow_rc_o(slow));
    ocd_osc_divider u_ocd_osc_divider (.clock_i(clock_i), .reset_i(reset_i),
        .fast_internal_rc_i(rc), .osc_in_pin_i(pri), .secondary_osc_in_pin_i(sec),
        .slow_internal_rc_i(slow), .initial_source_sel_i(strap), .primary_mode_sel_i(mode),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
        .sys_tick_o(sys_t), .instr_tick_o(ins_t), .peripheral_time_base_o(ptb),
        .instr_clk_o(ins_c), .watchdog_timer_tick_o(wdt), .clock_fail_monitor_tick_o(cfm),
        .rc_tune_o(tune), .primary_amp_en_o(pamp), .secondary_amp_en_o(samp),
        .current_source_code_o(cur));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        n_sys += int'(sys_t === 1'b1);
        n_ins += int'(ins_t === 1'b1);
        n_wdt += int'(wdt === 1'b1);
    end
    task automatic check(input bit ok, input string msg);
        compares++;
        if (!ok) begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    function automatic bit near(input int a, input int b);
        return a >= b - 2 && a <= b + 2;
    endfunction
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        check((rdata & m) === e, "register read");
    endtask
    task automatic switch_to(input logic [2:0] s);
        reg_wr(OCD_ADDR_CTRL, {5'h00, s, 8'h01});
    endtask
    // Window of 25600 ns: 320 fast RC, 256 primary, 160 secondary, 128 slow edges
    task automatic measure(input int e);
        repeat (300) @(posedge clock_i);
        #1;
        n_sys = 0;
        n_ins = 0;
        n_wdt = 0;
        repeat (2560) @(posedge clock_i);
        #1;
        check(near(n_sys, e), "system tick count");
        check(near(n_ins, n_sys / 2), "instruction tick count");
        check(near(n_wdt, 128), "watchdog tick count");
    endtask
    task automatic do_reset(input logic [2:0] s, input logic [1:0] m);
        @(posedge clock_i);
        reset_i <= 1'b1;
        strap <= s;
        mode <= m;
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        repeat (3) @(posedge clock_i);
    endtask
    task automatic t_reset();
        check(cur === 3'h7, "erased strap source");
        reg_rd(OCD_ADDR_CLOCK_DIVISOR_REG, 16'h0040, 16'hFFFF);
        reg_rd(OCD_ADDR_FBDIV, 16'h0030, 16'hFFFF);
        reg_rd(OCD_ADDR_CTRL, 16'h7000, 16'h7001);
        reg_rd(4'h9, 16'h0000, 16'hFFFF);
    endtask
    task automatic t_tune();
        reg_wr(OCD_ADDR_TUNE, 16'hFFFF);
        reg_rd(OCD_ADDR_TUNE, 16'h003F, 16'hFFFF);
        check(tune === 6'h3F, "tune output");
        reg_wr(OCD_ADDR_TUNE, 16'h002A);
        reg_wr(4'h9, 16'h1234);
        reg_rd(OCD_ADDR_TUNE, 16'h002A, 16'hFFFF);
        reg_rd(4'h9, 16'h0000, 16'hFFFF);
    endtask
    task automatic t_rc_post();
        for (int c = 0; c < 8; c++) begin
            reg_wr(OCD_ADDR_CLOCK_DIVISOR_REG, {5'h00, c[2:0], 8'h40});
            measure(320 / (c == 7 ? 256 : (1 << c)));
        end
        switch_to(3'h6);
        measure(20);
    endtask
    task automatic t_sources();
        switch_to(3'h0);
        measure(320);
        switch_to(3'h2);
        measure(256);
        check(pamp === 1'b1, "primary amplifier on");
        switch_to(3'h4);
        measure(160);
        check(samp === 1'b1, "secondary amplifier on");
        switch_to(3'h5);
        reg_rd(OCD_ADDR_CTRL, 16'h5000, 16'h7001);
        measure(128);
    endtask
    task automatic pll(input logic [2:0] s, input logic [4:0] p, input logic [8:0] f,
                       input logic [1:0] q, input int e);
        reg_wr(OCD_ADDR_CLOCK_DIVISOR_REG, {8'h00, q, 1'b0, p});
        reg_wr(OCD_ADDR_FBDIV, {7'h00, f});
        switch_to(s);
        measure(e);
    endtask
    task automatic t_pll();
        pll(3'h3, 5'h00, 9'h01E, 2'h0, 2048);
        pll(3'h3, 5'h00, 9'h01E, 2'h1, 1024);
        pll(3'h3, 5'h00, 9'h01E, 2'h2, 1024);
        pll(3'h3, 5'h00, 9'h01E, 2'h3, 512);
        pll(3'h3, 5'h1F, 9'h040, 2'h0, 256);
        pll(3'h1, 5'h00, 9'h01E, 2'h3, 640);
    endtask
    task automatic t_strap();
        do_reset(3'h2, OCD_PRI_EXT);
        check(cur === 3'h2, "strap source primary");
        check(pamp === 1'b0, "external clock needs no amplifier");
        measure(256);
    endtask
    task automatic report_and_stop();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        reset_i = 1'b1;
        strap = 3'h7;
        mode = OCD_PRI_STD;
        addr_i = 4'h0;
        wdata_i = 16'h0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        t_reset();
        t_tune();
        t_rc_post();
        t_sources();
        t_pll();
        t_strap();
        report_and_stop();
    end
    initial begin
        #700000;
        failures++;
        report_and_stop();
    end
endmodule
